// File: hdl/svic_cfg.svh
// constants of the single-vector interrupt control block
// assumes a 4-bit core with nibble-wide special registers
`ifndef SVIC_CFG_SVH
`define SVIC_CFG_SVH

// -------------------------------------------------------------
// entry vectors
// -------------------------------------------------------------
`define SVIC_VEC_RESET        12'h000
`define SVIC_VEC_WAKE         12'h004
`define SVIC_VEC_IRQ          12'h008

// -------------------------------------------------------------
// register addresses and fields
// -------------------------------------------------------------
`define SVIC_ADDR_STATUS      5'h00
`define SVIC_ADDR_CTRL        5'h09
`define SVIC_BIT_ZERO         0
`define SVIC_BIT_CARRY        1
`define SVIC_BIT_PWMREQ       2
`define SVIC_BIT_RUN          0
`define SVIC_BIT_GIE          1

// -------------------------------------------------------------
// request rate
// -------------------------------------------------------------
`define SVIC_CLK_HZ           250000000
`define SVIC_REQ_HZ           32768
`define SVIC_REQ_CYCLES       (`SVIC_CLK_HZ / `SVIC_REQ_HZ)

`endif

// File: hdl/svic_pkg.sv
// types shared by the single-vector interrupt control block
// assumes svic_cfg.svh is on the include path
package svic_pkg;

  // core context saved on entry and restored on return
  typedef struct packed {
    logic [11:0] pc;
    logic [3:0]  page_high_nibble;
    logic [3:0]  mem_addr_high_nibble;
    logic        carry_flag;
    logic        zero_flag;
  } svic_ctx_s;

  // special-register write port from the core
  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [3:0] data;
  } svic_sfr_s;

  typedef enum logic [1:0] {
    SVIC_RUN,
    SVIC_ACCEPT,
    SVIC_SERVICE
  } svic_state_e;

endpackage

// File: hdl/svic_top.sv
// single-vector interrupt controller for a 4-bit core
// assumes the sequencer applies pc_load/pc_value and the restored context
// on the cycle after they are shown, and reports flag changes via flag_we
//
// Operation
// - fixed vectors: reset 0, wake 4, irq 8
// - one shared entry, no priority encoding
// - request recurs at nominal 32768 Hz
// - enable and flag high: accept next clock
// - one clock saves context, loads entry
// - entering service clears global enable
// - flag stays set; software write clears
// - irq return restores context, sets enable
// - subroutine return decoded separately, no restore
// - one level; single shadow context only
// - status: flag b2, carry b1, zero b0
// - control: enable b1, modulator run b0
// - flag set on each modulator cycle end
`timescale 1ns/1ns
`include "svic_cfg.svh"

module svic_top #(
  parameter int REQ_CYCLES = `SVIC_REQ_CYCLES
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // core sequencer
  input  wire svic_pkg::svic_ctx_s   live_ctx,
  input  wire logic                  flag_we,
  input  wire logic                  return_from_irq,
  input  wire logic                  return_from_sub,
  input  wire logic                  halt_wake,
  input  wire svic_pkg::svic_sfr_s   sfr_wr,
  input  wire logic [4:0]            sfr_rd_addr,
  // outputs to the core
  output logic                       pc_load,
  output logic [11:0]                pc_value,
  output logic                       ctx_restore,
  output svic_pkg::svic_ctx_s        restore_ctx,
  output logic [3:0]                 sfr_rd_data,
  // modulator side
  output logic                       modulator_run_enable,
  output logic                       pwm_cycle_tick
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  svic_pkg::svic_state_e st_reg, st_next;
  svic_pkg::svic_ctx_s   shadow_reg, shadow_next;
  svic_pkg::svic_ctx_s   rctx_reg, rctx_next;
  logic                  pwm_request_flag_reg, pwm_request_flag_next;
  logic                  carry_flag_reg, carry_flag_next;
  logic                  zero_flag_reg, zero_flag_next;
  logic                  irq_global_enable_reg, irq_global_enable_next;
  logic                  run_reg, run_next;
  logic [31:0]           cnt_reg, cnt_next;
  logic                  tick_reg, tick_next;
  logic                  pcl_reg, pcl_next;
  logic [11:0]           pcv_reg, pcv_next;
  logic                  rst_reg, rst_next;
  logic [3:0]            rd_reg, rd_next;
  logic                  wr_status, wr_ctrl;

  assign wr_status = sfr_wr.wr && (sfr_wr.addr == `SVIC_ADDR_STATUS);
  assign wr_ctrl   = sfr_wr.wr && (sfr_wr.addr == `SVIC_ADDR_CTRL);

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb
  begin
    st_next                = st_reg;
    shadow_next            = shadow_reg;
    rctx_next              = rctx_reg;
    pwm_request_flag_next  = pwm_request_flag_reg;
    carry_flag_next        = carry_flag_reg;
    zero_flag_next         = zero_flag_reg;
    irq_global_enable_next = irq_global_enable_reg;
    run_next               = run_reg;
    cnt_next               = cnt_reg;
    tick_next              = 1'b0;
    pcl_next               = 1'b0;
    pcv_next               = pcv_reg;
    rst_next               = 1'b0;

    // core flag updates and direct writes
    if (flag_we)
    begin
      carry_flag_next = live_ctx.carry_flag;
      zero_flag_next  = live_ctx.zero_flag;
    end
    if (wr_status)
    begin
      carry_flag_next = sfr_wr.data[`SVIC_BIT_CARRY];
      zero_flag_next  = sfr_wr.data[`SVIC_BIT_ZERO];
      if (!sfr_wr.data[`SVIC_BIT_PWMREQ])
        pwm_request_flag_next = 1'b0;
    end
    if (wr_ctrl)
    begin
      run_next               = sfr_wr.data[`SVIC_BIT_RUN];
      irq_global_enable_next = sfr_wr.data[`SVIC_BIT_GIE];
    end

    // modulator cycle timebase; a stopped modulator raises no request
    if (run_reg)
    begin
      if (cnt_reg >= 32'(REQ_CYCLES - 1))
      begin
        cnt_next              = '0;
        tick_next             = 1'b1;
        pwm_request_flag_next = 1'b1;
      end
      else
        cnt_next = cnt_reg + 32'd1;
    end
    else
      cnt_next = '0;

    // halt wake vectors whatever the enable and flag; the accept clock and an irq return override its load
    if (halt_wake)
    begin
      pcl_next = 1'b1;
      pcv_next = `SVIC_VEC_WAKE;
    end

    unique case (st_reg)
      svic_pkg::SVIC_RUN:
        if (irq_global_enable_reg && pwm_request_flag_reg && !halt_wake)
          st_next = svic_pkg::SVIC_ACCEPT;
      svic_pkg::SVIC_ACCEPT:
      begin
        // single clock: capture context, vector, drop enable
        shadow_next            = live_ctx;
        shadow_next.carry_flag = carry_flag_reg;
        shadow_next.zero_flag  = zero_flag_reg;
        pcl_next               = 1'b1;
        pcv_next               = `SVIC_VEC_IRQ;
        irq_global_enable_next = 1'b0;
        st_next                = svic_pkg::SVIC_SERVICE;
      end
      svic_pkg::SVIC_SERVICE:
        // subroutine returns pass through untouched
        if (return_from_irq && !return_from_sub)
        begin
          rctx_next              = shadow_reg;
          rst_next               = 1'b1;
          pcl_next               = 1'b1;
          pcv_next               = shadow_reg.pc;
          carry_flag_next        = shadow_reg.carry_flag;
          zero_flag_next         = shadow_reg.zero_flag;
          irq_global_enable_next = 1'b1;
          st_next                = svic_pkg::SVIC_RUN;
        end
    endcase

    // no second acceptance while in service even if software sets enable
    if (st_reg == svic_pkg::SVIC_SERVICE && st_next == svic_pkg::SVIC_SERVICE && wr_ctrl)
      irq_global_enable_next = 1'b0;

    unique case (sfr_rd_addr)
      `SVIC_ADDR_STATUS: rd_next = {1'b0, pwm_request_flag_reg, carry_flag_reg, zero_flag_reg};
      `SVIC_ADDR_CTRL:   rd_next = {2'b00, irq_global_enable_reg, run_reg};
      default:           rd_next = 4'h0;
    endcase
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      st_reg                <= svic_pkg::SVIC_RUN;
      shadow_reg            <= '0;
      rctx_reg              <= '0;
      pwm_request_flag_reg  <= 1'b0;
      carry_flag_reg        <= 1'b0;
      zero_flag_reg         <= 1'b0;
      irq_global_enable_reg <= 1'b0;
      run_reg               <= 1'b0;
      cnt_reg               <= '0;
      tick_reg              <= 1'b0;
      pcl_reg               <= 1'b1;
      pcv_reg               <= `SVIC_VEC_RESET;
      rst_reg               <= 1'b0;
      rd_reg                <= 4'h0;
    end
    else
    begin
      st_reg                <= st_next;
      shadow_reg            <= shadow_next;
      rctx_reg              <= rctx_next;
      pwm_request_flag_reg  <= pwm_request_flag_next;
      carry_flag_reg        <= carry_flag_next;
      zero_flag_reg         <= zero_flag_next;
      irq_global_enable_reg <= irq_global_enable_next;
      run_reg               <= run_next;
      cnt_reg               <= cnt_next;
      tick_reg              <= tick_next;
      pcl_reg               <= pcl_next;
      pcv_reg               <= pcv_next;
      rst_reg               <= rst_next;
      rd_reg                <= rd_next;
    end
  end

  assign pc_load              = pcl_reg;
  assign pc_value             = pcv_reg;
  assign ctx_restore          = rst_reg;
  assign restore_ctx          = rctx_reg;
  assign sfr_rd_data          = rd_reg;
  assign modulator_run_enable = run_reg;
  assign pwm_cycle_tick       = tick_reg;

endmodule

// File: sim/svic_assertions.sv
// port assertions for the single-vector interrupt controller
// assumes it is bound into every svic_top instance
`timescale 1ns/1ns
module svic_checker #(
  parameter int REQ_CYCLES = 16
) (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire svic_pkg::svic_ctx_s live_ctx,
  input wire logic                flag_we,
  input wire logic                return_from_irq,
  input wire logic                return_from_sub,
  input wire logic                halt_wake,
  input wire svic_pkg::svic_sfr_s sfr_wr,
  input wire logic [4:0]          sfr_rd_addr,
  input wire logic                pc_load,
  input wire logic [11:0]         pc_value,
  input wire logic                ctx_restore,
  input wire svic_pkg::svic_ctx_s restore_ctx,
  input wire logic [3:0]          sfr_rd_data,
  input wire logic                modulator_run_enable,
  input wire logic                pwm_cycle_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // a shorter period than nine cycles would trip the gap check
  sequence s_quiet;
    !pwm_cycle_tick [*8];
  endsequence
  sequence s_sub_ret;
    return_from_sub;
  endsequence
  chk_vector_fixed: assert property (pc_load && !ctx_restore |-> pc_value inside {12'h000, 12'h004, 12'h008})
    else $error("vector load outside the fixed entries");
  chk_wake_entry: assert property (halt_wake |-> ##[1:2] (pc_load && pc_value == 12'h004))
    else $error("wake did not vector to four");
  chk_restore_pc: assert property (ctx_restore |-> pc_load && pc_value == restore_ctx.pc)
    else $error("restore without saved pc load");
  chk_restore_cause: assert property (ctx_restore |-> $past(return_from_irq) && !$past(return_from_sub))
    else $error("restore without interrupt return");
  chk_sub_quiet: assert property (s_sub_ret |=> !ctx_restore)
    else $error("subroutine return restored context");
  chk_tick_gap: assert property (pwm_cycle_tick |=> s_quiet)
    else $error("modulator ticks too close");
  chk_run_write: assert property (sfr_wr.wr && sfr_wr.addr == 5'h09 |=> modulator_run_enable == $past(sfr_wr.data[0]))
    else $error("run enable did not follow write");
  chk_unmapped_zero: assert property (!(sfr_rd_addr inside {5'h00, 5'h09}) |=> sfr_rd_data == 4'h0)
    else $error("unmapped read not zero");
  chk_reserved_zero: assert property (sfr_rd_addr == 5'h09 |=> sfr_rd_data[3:2] == 2'b00)
    else $error("control reserved bits not zero");
  chk_flag_on_tick: assert property (pwm_cycle_tick && sfr_rd_addr == 5'h00 |=> sfr_rd_data[2] && !sfr_rd_data[3])
    else $error("request flag not set by tick");
endmodule
bind svic_top svic_checker #(.REQ_CYCLES(REQ_CYCLES)) i_svic_checker (.mclk(mclk), .reset_n(reset_n),
  .live_ctx(live_ctx), .flag_we(flag_we), .return_from_irq(return_from_irq), .return_from_sub(return_from_sub),
  .halt_wake(halt_wake), .sfr_wr(sfr_wr), .sfr_rd_addr(sfr_rd_addr), .pc_load(pc_load), .pc_value(pc_value),
  .ctx_restore(ctx_restore), .restore_ctx(restore_ctx), .sfr_rd_data(sfr_rd_data),
  .modulator_run_enable(modulator_run_enable), .pwm_cycle_tick(pwm_cycle_tick));

// File: sim/svic_core_model.sv
// behavioural core sequencer facing the interrupt controller
// assumes a free-running pc and random nibbles from the bench
`timescale 1ns/1ns
module svic_core_model (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                pc_load,
  input  wire logic [11:0]         pc_value,
  input  wire logic                ctx_restore,
  input  wire svic_pkg::svic_ctx_s restore_ctx,
  input  wire logic [9:0]          seed,
  output svic_pkg::svic_ctx_s      live_ctx
);
  always_ff @(posedge mclk)
    if (!reset_n)
      live_ctx <= '0;
    else
    begin
      live_ctx.pc <= pc_load ? pc_value : live_ctx.pc + 12'h001;
      // restored nibbles and flags win over the bench's random values
      {live_ctx.page_high_nibble, live_ctx.mem_addr_high_nibble, live_ctx.carry_flag, live_ctx.zero_flag} <=
        ctx_restore ? restore_ctx[9:0] : seed;
    end
endmodule

// File: sim/test_single_vector_irq_control.sv
// self-checking bench for the single-vector interrupt controller
// assumes a 16-cycle modulator period
`timescale 1ns/1ns
module test_single_vector_irq_control;
  localparam int REQ = 16;
  logic                mclk = 1'b0;
  logic                reset_n = 1'b0;
  logic                flag_we = 1'b0;
  logic                return_from_irq = 1'b0;
  logic                return_from_sub = 1'b0;
  logic                halt_wake = 1'b0;
  svic_pkg::svic_sfr_s sfr_wr = '0;
  logic [4:0]          sfr_rd_addr = 5'h00;
  logic [15:0]         rnd = 16'h002A;
  int                  fail_count = 0;
  int                  n_checks = 0;
  int                  n;
  logic [3:0]          d;
  logic [1:0]          cz;
  svic_pkg::svic_ctx_s live_ctx, prev_ctx, saved, restore_ctx;
  logic                pc_load, ctx_restore, modulator_run_enable, pwm_cycle_tick;
  logic [11:0]         pc_value;
  logic [3:0]          sfr_rd_data;
  always #2 mclk = ~mclk;
  always @(posedge mclk) rnd <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
  always @(posedge mclk) prev_ctx <= live_ctx;
  svic_top #(.REQ_CYCLES(REQ)) i_svic_top (.mclk(mclk), .reset_n(reset_n), .live_ctx(live_ctx),
    .flag_we(flag_we), .return_from_irq(return_from_irq), .return_from_sub(return_from_sub), .halt_wake(halt_wake),
    .sfr_wr(sfr_wr), .sfr_rd_addr(sfr_rd_addr), .pc_load(pc_load), .pc_value(pc_value), .ctx_restore(ctx_restore),
    .restore_ctx(restore_ctx), .sfr_rd_data(sfr_rd_data), .modulator_run_enable(modulator_run_enable),
    .pwm_cycle_tick(pwm_cycle_tick));
  svic_core_model i_svic_core_model (.mclk(mclk), .reset_n(reset_n), .pc_load(pc_load), .pc_value(pc_value),
    .ctx_restore(ctx_restore), .restore_ctx(restore_ctx), .seed(rnd[9:0]), .live_ctx(live_ctx));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [3:0] v);
    sfr_wr = '{1'b1, a, v};
    step(1);
    sfr_wr.wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    sfr_rd_addr = a;
    step(1);
    d = sfr_rd_data;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    step(5);
    check(pc_load, 1'b1);
    check(pc_value, 12'h000);
    reset_n = 1'b1;
    rd(5'h00);
    check(d, 4'h0);
    rd(5'h09);
    check(d, 4'h0);
    rd({1'b1, rnd[3:0]});
    check(d, 4'h0);
    pulse(halt_wake);
    for (n = 0; n < 4 && pc_load !== 1'b1; n++) step(1);
    check(pc_value, 12'h004);
    wr(5'h09, {rnd[3:2], 2'b01});
    rd(5'h09);
    check(d, 4'h1);
    for (n = 0; n < 40 && pwm_cycle_tick !== 1'b1; n++) step(1);
    step(1);
    for (n = 1; n < 40 && pwm_cycle_tick !== 1'b1; n++) step(1);
    check(n[11:0], 12'(REQ));
    rd(5'h00);
    check(d[2], 1'b1);
    wr(5'h00, 4'h0);
    rd(5'h00);
    check(d[2], 1'b0);
    // clear written on the very edge of a cycle end: the set must win
    for (n = 0; n < 40 && pwm_cycle_tick !== 1'b1; n++) step(1);
    step(REQ - 1);
    wr(5'h00, 4'h0);
    rd(5'h00);
    check(d[2], 1'b1);
    pulse(flag_we);
    cz = {prev_ctx.carry_flag, prev_ctx.zero_flag};
    wr(5'h09, 4'h3);
    for (n = 0; n < 40 && pc_load !== 1'b1; n++) step(1);
    saved = prev_ctx;
    check(pc_value, 12'h008);
    rd(5'h09);
    check(d, 4'h1);
    rd(5'h00);
    check(d[2], 1'b1);
    wr(5'h09, 4'h3);
    for (n = 0; n < 20 && pc_load !== 1'b1; n++) step(1);
    check(pc_load, 1'b0);
    pulse(return_from_sub);
    check(ctx_restore, 1'b0);
    pulse(return_from_irq);
    check(ctx_restore, 1'b1);
    check(pc_value, saved.pc);
    check(restore_ctx[9:0], {saved.page_high_nibble, saved.mem_addr_high_nibble, cz});
    rd(5'h09);
    check(d, 4'h3);
    report_and_stop();
  end
endmodule
